// file: rtl/keypad_scan_debounce_engine.sv
// Keypad matrix scan engine with per-pin debouncing and its configuration registers.
// How it works
// R1: The debounce time code 0 to 5 selects 0.5 ms doubling to 16 ms, counted in oscillator ticks.
// R2: Each pin is debounced only when its bank enable bit is set, otherwise it passes straight on.
// R3: With no key press for the auto-sleep time (code 0 off, else 128 ms doubling) the engine sleeps.
// R4: Each row is held for 1 ms doubling to 128 ms per its code, counted in oscillator ticks.
// R5: Software must set the row scan time above the debounce time.
// R6: Row code 0 stops scanning and code n scans rows on pins 0 to n.
// R7: Column code n senses columns on pins 8 to 8+n.
// R8: The column report shows the pressed column as a zero bit and resets to all ones.
// R9: The row report shows the pressed row as a zero bit and resets to all ones.
// R10: Reading the row report returns the column report to all ones.
// R11: Reading the row report clears both reports, releases the interrupt and resumes scanning.
// R12: Oscillator source 0 stops the engine and debouncing, 1 takes the external clock, 2 the internal one.
// R13: While scanning, one row at a time is driven low and the first press found is latched with the interrupt.
module keypad_scan_debounce_engine
	import keypad_pkg::*;
#(
	parameter logic [keypad_pkg::TICK_W-1:0] DEB_BASE = keypad_pkg::DEB_BASE_TICKS,
	parameter logic [keypad_pkg::TICK_W-1:0] SCAN_BASE = keypad_pkg::SCAN_BASE_TICKS,
	parameter logic [keypad_pkg::TICK_W-1:0] SLEEP_BASE = keypad_pkg::SLEEP_BASE_TICKS
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Register port.
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	output logic regRvalid,
	// Oscillator selection and external clock pin.
	input wire logic [1:0] oscSource,
	input wire logic externalClockInput,
	// I/O pins: bank A is pins 7..0, bank B is pins 15..8.
	input wire logic [15:0] ioIn,
	output logic [7:0] rowOut,
	output logic [7:0] rowOe,
	output logic [15:0] debouncedIn,
	// Interrupt to the host.
	output logic irqOutN
);

	logic [7:0] debCfg_r, debEnB_r, debEnA_r, keyTiming_r, keySize_r;
	logic [7:0] colRep_r, rowRep_r;
	logic [15:0] ioMeta_r, ioSync_r;
	logic [2:0] extSync_r;
	logic [6:0] divCnt_r;
	logic tick_r;
	scan_state_t state_r;
	logic [2:0] rowIdx_r;
	logic [TICK_W-1:0] rowTimer_r, sleepTimer_r;
	logic [2:0] debCode, scanCode, sleepCode, rowCode, colCode;
	logic [TICK_W-1:0] debDur, rowDur, sleepDur;
	logic [7:0] colMask, rowMask, colDb;
	logic engineOn, colHit, rowReadHit;

	// Configuration fields and derived durations.
	assign debCode = debCfg_r[DEB_TIME_LSB +: FIELD_W];
	assign scanCode = keyTiming_r[SCAN_TIME_LSB +: FIELD_W];
	assign sleepCode = keyTiming_r[SLEEP_TIME_LSB +: FIELD_W];
	assign rowCode = keySize_r[ROW_CNT_LSB +: FIELD_W];
	assign colCode = keySize_r[COL_CNT_LSB +: FIELD_W];
	assign debDur = DEB_BASE << ((debCode > DEB_CODE_MAX) ? DEB_CODE_MAX : debCode); // see R1
	assign rowDur = SCAN_BASE << scanCode; // see R4
	assign sleepDur = SLEEP_BASE << (sleepCode - 3'h1); // see R3
	assign colMask = 8'hFF >> (3'h7 - colCode); // see R7
	assign rowMask = 8'hFF >> (3'h7 - rowCode); // see R6
	assign colDb = debouncedIn[15:8];
	assign colHit = (colDb | ~colMask) != 8'hFF;
	assign engineOn = (oscSource == OSC_EXTERNAL) || (oscSource == OSC_INTERNAL); // see R12
	assign rowReadHit = regRead && (regAddr == OFF_KEY_ROW);

	// Pin and external clock synchronisers; the edge detect compares the second and third stages.
	always_ff @(posedge clk) begin
		if (rst) begin
			ioMeta_r <= 16'hFFFF;
			ioSync_r <= 16'hFFFF;
			extSync_r <= 3'h0;
		end else begin
			ioMeta_r <= ioIn;
			ioSync_r <= ioMeta_r;
			extSync_r <= {extSync_r[1:0], externalClockInput};
		end
	end

	// Oscillator tick: internal divider or rising edge of the external clock.
	always_ff @(posedge clk) begin
		if (rst) begin
			divCnt_r <= 7'h00;
			tick_r <= 1'b0;
		end else begin
			tick_r <= 1'b0;
			divCnt_r <= 7'h00;
			if (oscSource == OSC_INTERNAL) begin // see R12
				if (divCnt_r == 7'(INT_OSC_DIV - 1)) begin
					tick_r <= 1'b1;
				end else begin
					divCnt_r <= divCnt_r + 7'h01;
				end
			end else if (oscSource == OSC_EXTERNAL) begin
				tick_r <= extSync_r[1] && !extSync_r[2];
			end
		end
	end

	// Debouncers, one per pin, bypassed when the engine clock is off.
	for (genvar i = 0; i < 16; i++) begin : g_deb
		debounce_cell #(
			.CNT_W(TICK_W)
		) u_deb (
			.clk(clk),
			.rst(rst),
			.tick(tick_r),
			.enable(engineOn && ((i < 8) ? debEnA_r[i % 8] : debEnB_r[i % 8])), // see R2
			.duration(debDur),
			.pinIn(ioSync_r[i]),
			.pinOut(debouncedIn[i])
		);
	end

	// Configuration register writes.
	always_ff @(posedge clk) begin
		if (rst) begin
			debCfg_r <= RST_CONFIG;
			debEnB_r <= RST_CONFIG;
			debEnA_r <= RST_CONFIG;
			keyTiming_r <= RST_CONFIG;
			keySize_r <= RST_CONFIG;
		end else if (regWrite) begin
			case (regAddr)
				OFF_DEB_CFG: debCfg_r <= regWdata & MASK_DEB_CFG;
				OFF_DEB_EN_B: debEnB_r <= regWdata;
				OFF_DEB_EN_A: debEnA_r <= regWdata;
				OFF_KEY_TIMING: keyTiming_r <= regWdata & MASK_KEY_TIMING;
				OFF_KEY_SIZE: keySize_r <= regWdata & MASK_KEY_SIZE;
				default: ;
			endcase
		end
	end

	// Register reads, answered one cycle after the request.
	always_ff @(posedge clk) begin
		if (rst) begin
			regRdata <= 8'h00;
			regRvalid <= 1'b0;
		end else begin
			regRvalid <= regRead;
			case (regAddr)
				OFF_DEB_CFG: regRdata <= debCfg_r;
				OFF_DEB_EN_B: regRdata <= debEnB_r;
				OFF_DEB_EN_A: regRdata <= debEnA_r;
				OFF_KEY_TIMING: regRdata <= keyTiming_r;
				OFF_KEY_SIZE: regRdata <= keySize_r;
				OFF_KEY_COL: regRdata <= colRep_r; // see R8
				OFF_KEY_ROW: regRdata <= rowRep_r; // see R9
				default: regRdata <= 8'h00;
			endcase
		end
	end

	// Scan sequencer, key reports and interrupt.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= ST_IDLE;
			rowIdx_r <= 3'h0;
			rowTimer_r <= '0;
			sleepTimer_r <= '0;
			rowOe <= 8'h00;
			rowOut <= 8'hFF;
			colRep_r <= RST_REPORT;
			rowRep_r <= RST_REPORT;
			irqOutN <= 1'b1;
		end else begin
			if (rowReadHit) begin
				colRep_r <= RST_REPORT; // see R10
				rowRep_r <= RST_REPORT; // see R11
				irqOutN <= 1'b1;
			end
			case (state_r)
				ST_IDLE: begin
					rowOe <= 8'h00;
					rowIdx_r <= 3'h0;
					rowTimer_r <= '0;
					sleepTimer_r <= '0;
					if (engineOn && rowCode != 3'h0) begin
						state_r <= ST_SCAN;
					end
				end
				ST_SCAN: begin
					rowOe <= 8'h01 << rowIdx_r; // see R13
					rowOut <= ~(8'h01 << rowIdx_r);
					if (!engineOn || rowCode == 3'h0) begin // see R6
						state_r <= ST_IDLE;
						rowOe <= 8'h00;
					end else if (tick_r) begin
						sleepTimer_r <= sleepTimer_r + TICK_W'(1);
						if (rowTimer_r + TICK_W'(1) >= rowDur) begin // see R4
							rowTimer_r <= '0;
							if (colHit) begin
								colRep_r <= colDb | ~colMask; // see R8
								rowRep_r <= ~(8'h01 << rowIdx_r); // see R9
								irqOutN <= 1'b0; // see R13
								sleepTimer_r <= '0;
								state_r <= ST_HOLD;
							end else if (sleepCode != 3'h0 && sleepTimer_r >= sleepDur) begin
								state_r <= ST_SLEEP; // see R3
								rowIdx_r <= 3'h0;
							end else begin
								rowIdx_r <= (rowIdx_r >= rowCode) ? 3'h0 : rowIdx_r + 3'h1;
							end
						end else begin
							rowTimer_r <= rowTimer_r + TICK_W'(1);
						end
					end
				end
				ST_HOLD: begin
					if (rowReadHit) begin // see R11
						state_r <= ST_IDLE;
					end
				end
				ST_SLEEP: begin
					rowOe <= rowMask;
					rowOut <= 8'h00;
					if (!engineOn || rowCode == 3'h0 || colHit) begin
						state_r <= ST_IDLE;
						rowOe <= 8'h00; // Rows are released as soon as sleep ends.
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Checks on the design's own behaviour.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	irq_only_hold_a: assert property (!irqOutN |-> state_r == ST_HOLD) // see R13
		else $error("Interrupt low outside hold state.");
	row_read_clear_a: assert property ( // see R11
		rowReadHit && state_r == ST_HOLD |=> irqOutN && rowRep_r == 8'hFF && state_r == ST_IDLE)
		else $error("Row report read did not clear and release.");
	col_read_clear_a: assert property (rowReadHit && state_r == ST_HOLD |=> colRep_r == 8'hFF) // see R10
		else $error("Column report not cleared by row report read.");
	one_row_a: assert property ( // see R13
		state_r == ST_SCAN && $past(state_r) == ST_SCAN |-> $onehot(rowOe))
		else $error("Not exactly one row driven while scanning.");
	row_range_a: assert property (state_r == ST_SCAN |-> rowIdx_r <= rowCode) // see R6
		else $error("Row index beyond configured row count.");
	col_report_a: assert property (!irqOutN |-> (colRep_r & ~colMask) == ~colMask) // see R7
		else $error("Column report flags an unused column.");
	row_report_a: assert property ( // see R9
		!irqOutN |-> $onehot(~rowRep_r) && (~rowRep_r & ~rowMask) == 8'h00)
		else $error("Row report not a single enabled row.");
	scan_off_a: assert property ( // see R6
		rowCode == 3'h0 && state_r != ST_HOLD |=> rowOe == 8'h00 ##1 rowOe == 8'h00)
		else $error("Rows driven while scanning is off.");
	osc_off_a: assert property (oscSource == OSC_OFF |=> !tick_r) // see R12
		else $error("Tick produced with oscillator off.");
	deb_bypass_a: assert property ( // see R2
		!debEnB_r[0] && $stable(debEnB_r[0]) |=> debouncedIn[8] == $past(ioSync_r[8]))
		else $error("Disabled debouncer did not pass the pin through.");

	key_latched_c: cover property (state_r == ST_SCAN ##1 state_r == ST_HOLD);
	host_release_c: cover property (state_r == ST_HOLD ##1 state_r == ST_IDLE);
	sleep_enter_c: cover property (state_r == ST_SCAN ##1 state_r == ST_SLEEP);
	sleep_wake_c: cover property (state_r == ST_SLEEP ##1 state_r == ST_IDLE);

endmodule

// file: rtl/keypad_pkg.sv
// Package with register map, field layout, reset values and timing constants of the keypad engine.
package keypad_pkg;

	// Register offsets on the configuration port.
	localparam logic [7:0] OFF_DEB_CFG = 8'h22;
	localparam logic [7:0] OFF_DEB_EN_B = 8'h23;
	localparam logic [7:0] OFF_DEB_EN_A = 8'h24;
	localparam logic [7:0] OFF_KEY_TIMING = 8'h25;
	localparam logic [7:0] OFF_KEY_SIZE = 8'h26;
	localparam logic [7:0] OFF_KEY_COL = 8'h27;
	localparam logic [7:0] OFF_KEY_ROW = 8'h28;

	// Reset values.
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [7:0] RST_REPORT = 8'hFF;

	// Field positions (low bit of each 3-bit field).
	localparam int DEB_TIME_LSB = 0;
	localparam int SCAN_TIME_LSB = 0;
	localparam int SLEEP_TIME_LSB = 4;
	localparam int COL_CNT_LSB = 0;
	localparam int ROW_CNT_LSB = 3;
	localparam int FIELD_W = 3;

	// Write masks: unused bits are not stored and read as zero.
	localparam logic [7:0] MASK_DEB_CFG = 8'h07;
	localparam logic [7:0] MASK_KEY_TIMING = 8'h77;
	localparam logic [7:0] MASK_KEY_SIZE = 8'h3F;

	// Oscillator source selections.
	localparam logic [1:0] OSC_OFF = 2'h0;
	localparam logic [1:0] OSC_EXTERNAL = 2'h1;
	localparam logic [1:0] OSC_INTERNAL = 2'h2;

	// Largest debounce code with a defined duration.
	localparam logic [2:0] DEB_CODE_MAX = 3'h5;

	// Timing: all durations are counted in oscillator ticks at the nominal rate.
	localparam int CLK_KHZ = 200000;
	localparam int OSC_NOM_KHZ = 2000;
	localparam int INT_OSC_DIV = CLK_KHZ / OSC_NOM_KHZ;
	localparam int DEB_BASE_US = 500;
	localparam int SCAN_BASE_US = 1000;
	localparam int SLEEP_BASE_MS = 128;
	localparam int TICK_W = 26;
	localparam logic [TICK_W-1:0] DEB_BASE_TICKS = TICK_W'(DEB_BASE_US * OSC_NOM_KHZ / 1000);
	localparam logic [TICK_W-1:0] SCAN_BASE_TICKS = TICK_W'(SCAN_BASE_US * OSC_NOM_KHZ / 1000);
	localparam logic [TICK_W-1:0] SLEEP_BASE_TICKS = TICK_W'(SLEEP_BASE_MS * OSC_NOM_KHZ);

	// Scan engine states, Gray coded along idle, scan, hold.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SCAN = 2'b01,
		ST_HOLD = 2'b11,
		ST_SLEEP = 2'b10
	} scan_state_t;

endpackage

// file: rtl/debounce_cell.sv
// Debouncer for one input pin, counting oscillator ticks.
module debounce_cell #(
	parameter int CNT_W = 26
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Timing and control.
	input wire logic tick,
	input wire logic enable,
	input wire logic [CNT_W-1:0] duration,
	// Pin level in and filtered level out.
	input wire logic pinIn,
	output logic pinOut
);

	logic [CNT_W-1:0] cnt_r;

	// A changed level must stay stable for the whole duration before it is passed on.
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= '0;
			pinOut <= 1'b1;
		end else if (!enable) begin
			cnt_r <= '0;
			pinOut <= pinIn; // see R2
		end else if (pinIn == pinOut) begin
			cnt_r <= '0;
		end else if (tick) begin
			if (cnt_r + CNT_W'(1) >= duration) begin
				cnt_r <= '0;
				pinOut <= pinIn; // see R1
			end else begin
				cnt_r <= cnt_r + CNT_W'(1);
			end
		end
	end

endmodule

// file: tb/key_matrix_model.sv
// Passive key switch matrix with pull-ups on every line and one closable key.
module key_matrix_model (
	// Row drive from the engine.
	input wire logic [7:0] rowOut,
	input wire logic [7:0] rowOe,
	// Key selection from the bench.
	input wire logic pressed,
	input wire logic [2:0] pressRow,
	input wire logic [2:0] pressCol,
	// Pin levels seen by the engine.
	output logic [15:0] ioIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rowLvl;

	// Released rows float to the pull-up; a closed key ties its column to its row line.
	always_comb begin
		rowLvl = ~rowOe | rowOut;
		ioIn = {8'hFF, rowLvl};
		if (pressed) begin
			ioIn[8 + pressCol] = rowLvl[pressRow];
		end
	end
endmodule

// file: tb/tb_keypad_scan_debounce_engine.sv
// Self-checking bench for the keypad scan engine driving a key matrix model.
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errTotal++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_keypad_scan_debounce_engine import keypad_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regWdata = 8'h00;
	logic [7:0] regRdata;
	logic regRvalid;
	logic [1:0] oscSource = 2'h0;
	logic extClk = 1'b0;
	wire logic [15:0] ioIn;
	logic [7:0] rowOut;
	logic [7:0] rowOe;
	logic [15:0] debouncedIn;
	logic irqOutN;
	logic pressed = 1'b0;
	logic [2:0] pressRow = 3'h0;
	logic [2:0] pressCol = 3'h0;
	logic [7:0] rdVal;
	int errTotal = 0;
	int checks = 0;

	// Short bases keep one row period at eight oscillator ticks.
	keypad_scan_debounce_engine #(.DEB_BASE(TICK_W'(2)), .SCAN_BASE(TICK_W'(8)),
		.SLEEP_BASE(TICK_W'(32))) dut (.clk(clk), .rst(rst), .regAddr(regAddr),
		.regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
		.regRvalid(regRvalid), .oscSource(oscSource), .externalClockInput(extClk),
		.ioIn(ioIn), .rowOut(rowOut), .rowOe(rowOe), .debouncedIn(debouncedIn),
		.irqOutN(irqOutN));

	key_matrix_model matrix (.rowOut(rowOut), .rowOe(rowOe), .pressed(pressed),
		.pressRow(pressRow), .pressCol(pressCol), .ioIn(ioIn));

	// System clock and an unrelated external oscillator near 2 MHz.
	always #2.5 clk = ~clk;
	always #251.3 extClk = ~extClk;

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("checks=%0d errTotal=%0d", checks, errTotal);
		if (errTotal == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One register write, strobe held for a single cycle.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		regAddr = a;
		regWdata = d;
		regWrite = 1'b1;
		@(negedge clk);
		regWrite = 1'b0;
	endtask

	// One register read; data is taken in the cycle the answer stands.
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge clk);
		regRead = 1'b0;
		rdVal = regRdata;
		`CHK(regRvalid, 1'b1)
	endtask

	// Reset values, every field code, ignored bits and the read-only column report.
	task automatic testRegisters();
		logic [7:0] ad [7] = '{OFF_DEB_CFG, OFF_DEB_EN_B, OFF_DEB_EN_A, OFF_KEY_TIMING,
			OFF_KEY_SIZE, OFF_KEY_COL, OFF_KEY_ROW};
		logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF};
		for (int i = 0; i < 7; i++) begin
			rd(ad[i]);
			`CHK(rdVal, rv[i])
			wr(ad[i], 8'hA5);
		end
		for (int i = 1; i < 3; i++) begin
			rd(ad[i]);
			`CHK(rdVal, 8'hA5)
		end
		rd(OFF_KEY_COL);
		`CHK(rdVal, 8'hFF)
		rd(8'h30);
		`CHK(rdVal, 8'h00)
		for (int k = 0; k < 8; k++) begin
			wr(OFF_DEB_CFG, {5'h1F, 3'(k)});
			wr(OFF_KEY_TIMING, {1'b1, 3'(k), 1'b1, 3'(k)});
			wr(OFF_KEY_SIZE, {2'b11, 3'(k), 3'(k)});
			rd(OFF_DEB_CFG);
			`CHK(rdVal, {5'h00, 3'(k)})
			rd(OFF_KEY_TIMING);
			`CHK(rdVal, {1'b0, 3'(k), 1'b0, 3'(k)})
			rd(OFF_KEY_SIZE);
			`CHK(rdVal, {2'b00, 3'(k), 3'(k)})
		end
	endtask

	// Presses one key, waits for the interrupt, then checks both reports, the interrupt release and the column report's clearing.
	task automatic pressAndRead(input logic [2:0] r, input logic [2:0] c);
		int n;
		pressRow = r;
		pressCol = c;
		pressed = 1'b1;
		n = 0;
		while (irqOutN !== 1'b0 && n < 15000) begin
			@(negedge clk);
			n++;
		end
		`CHK(irqOutN, 1'b0)
		pressed = 1'b0;
		rd(OFF_KEY_COL);
		`CHK(rdVal, ~(8'h01 << c))
		rd(OFF_KEY_ROW);
		`CHK(rdVal, ~(8'h01 << r))
		`CHK(irqOutN, 1'b1)
		rd(OFF_KEY_COL);
		`CHK(rdVal, 8'hFF)
	endtask

	// Full matrix, debounced columns: one key is latched and cleared by the row read.
	task automatic testKey(input logic [1:0] src, input logic [2:0] r, input logic [2:0] c);
		@(negedge clk);
		oscSource = src;
		wr(OFF_DEB_CFG, 8'h00);
		wr(OFF_DEB_EN_B, 8'hFF);
		wr(OFF_KEY_TIMING, 8'h00);
		wr(OFF_KEY_SIZE, 8'h3F);
		repeat (2000) @(negedge clk);
		`CHK($countones(rowOut | ~rowOe), 7)
		pressAndRead(r, c);
	endtask

	// Idle scanning falls asleep with all rows low; a key wakes the engine and is then reported.
	task automatic testSleep(input logic [7:0] enB, input logic filtered);
		@(negedge clk);
		oscSource = OSC_INTERNAL;
		wr(OFF_DEB_EN_B, enB);
		wr(OFF_KEY_TIMING, 8'h10);
		wr(OFF_KEY_SIZE, 8'h3F);
		repeat (6000) @(negedge clk);
		`CHK(rowOe, 8'hFF)
		`CHK(rowOut, 8'h00)
		`CHK(debouncedIn, 16'hFF00)
		pressRow = 3'h3;
		pressCol = 3'h2;
		pressed = 1'b1;
		repeat (4) @(negedge clk);
		`CHK(debouncedIn[10], filtered)
		pressAndRead(3'h3, 3'h2);
	endtask

	// A key that the current setup must not report within a full scan.
	task automatic testNoKey(input logic [1:0] src, input logic [7:0] sz, input logic [2:0] c);
		@(negedge clk);
		oscSource = src;
		wr(OFF_KEY_SIZE, sz);
		pressRow = 3'h1;
		pressCol = c;
		pressed = 1'b1;
		repeat (7000) @(negedge clk);
		`CHK(irqOutN, 1'b1)
		pressed = 1'b0;
	endtask

	// Main sequence.
	initial begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		testRegisters();
		testKey(OSC_INTERNAL, 3'h2, 3'h5);
		testKey(OSC_EXTERNAL, 3'h7, 3'h0);
		testNoKey(OSC_INTERNAL, 8'h07, 3'h0);
		`CHK(rowOe, 8'h00)
		testNoKey(OSC_INTERNAL, 8'h38, 3'h3);
		testNoKey(OSC_OFF, 8'h3F, 3'h0);
		`CHK(rowOe, 8'h00)
		testSleep(8'hFF, 1'b1);
		testSleep(8'h00, 1'b0);
		summarize();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		#480000;
		errTotal++;
		summarize();
	end
endmodule
